// ===== hw/core_cfg.svh
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// ==========================================================================
// Timing.
`define CLK_PERIOD_NS 40
`define POR_DELAY_NS 500000
`define POR_DELAY_CYC ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHI_ONE_CYC 4'h4
`define PHI_LONG_CYC 4'hA

// ==========================================================================
// Addresses and reset values.
`define RESET_PC 12'h000
`define VEC_TIMER 12'h020
`define VEC_EXT 12'h0A0
`define PORT_CLEAR 8'h00
`define CTRL_RESET 8'h00
`define TEST_OFF 2'h0
`define TEST_MID 2'h1

// ==========================================================================
// Opcodes.
`define PARTIAL_SLEEP_OP 8'h2D
`define FULL_SLEEP_OP 8'h2F
`define ADD_CARRY_OP 8'h19
`define OP_INCREMENT 8'h1F
`define OP_ADD_IMM 8'h24
`define OP_AND_IMM 8'h21
`define OP_OR_IMM 8'h22
`define OP_XOR_IMM 8'h23
`define OP_CMP_IMM 8'h25
`define OP_COMPLEMENT 8'h18
`define OP_LOAD_IMM 8'h20
`define OP_SHR1 8'h12
`define OP_SHL1 8'h13
`define OP_SHR4 8'h14
`define OP_SHL4 8'h15
`define OP_LOAD_SHORT_HI 4'h7

// ==========================================================================
// Register offsets and fields.
`define REG_TIMER_IRQ_CONTROL 4'h0
`define REG_STATUS 4'h1
`define REG_ACC 4'h2
`define REG_PC 4'h3
`define REG_STACK 4'h4
`define REG_PORT4 4'h5
`define REG_PORT7 4'h8
`define CTRL_EXT_EN 0
`define CTRL_EXT_HI 2
`define CTRL_MODE 4
`define CTRL_PRESC 7:5
`define ST_IRQ_FLAG 4

`endif

// ===== hw/core_pkg.sv
package core_pkg;

	// ======================================================================
	// Core sequencing states.
	typedef enum logic [2:0] {
		ST_POR_WAIT, ST_POR_DELAY, ST_EXT_RST, ST_FETCH,
		ST_OPERAND, ST_EXEC, ST_PART_SLEEP, ST_FULL_SLEEP
	} core_phase_type;

	typedef enum logic [1:0] {TM_OFF, TM_MID, TM_HIGH} test_mode_type;

	// ======================================================================
	// Carriers.
	typedef struct packed {
		logic ovf;
		logic zero;
		logic cry;
		logic sign;
	} flag_type;

	typedef logic [3:0][7:0] port_bank_type;

	typedef struct packed {
		logic rst_n;
		logic ext_irq;
		logic [1:0] test;
		logic [7:0] port5;
		logic supply_ok;
		logic clocks_ok;
		logic bias_ok;
	} pin_bundle_type;

	typedef struct packed {
		logic [7:0] acc;
		flag_type flg;
		logic two_byte;
	} alu_res_type;

	typedef struct packed {
		core_phase_type state;
		logic [15:0] cnt;
		logic phi;
		logic [1:0] mcyc;
		logic [7:0] op;
		logic [7:0] imm;
		logic [11:0] pc;
		logic [11:0] stack;
		logic [7:0] acc;
		flag_type flg;
		logic irq_control_flag;
		logic [7:0] timer_irq_control_reg;
		logic tmr_req;
		logic ext_req;
		logic ext_prev;
		port_bank_type ports;
		logic [7:0] p4;
		logic strobe;
		logic timer_rst;
		logic [15:0] rdata;
	} core_state_type;

endpackage

// ===== hw/pin_sync.sv
`timescale 1ns/1ns

// Three-stage synchroniser; a bit changes once stages two and three agree.
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Pins and filtered levels
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_state_type;

	sync_state_type st_ff, nxt_st;

	if (W < 1) begin : g_bad_width
		$error("pin_sync width must be positive");
	end

	// Shift the pins in and accept a bit only when stages two and three agree.
	always_comb begin
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.q = (st_ff.s2 & st_ff.s3) | (st_ff.q & (st_ff.s2 ^ st_ff.s3));
	end

	// State register.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pin_out = st_ff.q;

endmodule // pin_sync

// ===== hw/acc_alu.sv
`timescale 1ns/1ns
`include "core_cfg.svh"

// Accumulator group decoder and arithmetic; purely combinational.
module acc_alu
	import core_pkg::*;
(
	// Instruction bytes
	input wire logic [7:0] op,
	input wire logic [7:0] imm,
	// Current accumulator and flags
	input wire logic [7:0] acc,
	input wire flag_type flg,
	// Result
	output alu_res_type res
);

	logic [7:0] opa;
	logic [7:0] opb;
	logic [7:0] lres;
	logic [8:0] sum;
	logic cin;
	logic c7;
	logic do_add;
	logic do_log;
	logic keep_acc;

	// Decode the opcode, then form sum or logic result and flags.
	always_comb begin
		opa = acc;
		opb = 8'h00;
		cin = 1'b0;
		do_add = 1'b0;
		do_log = 1'b0;
		keep_acc = 1'b0;
		lres = acc;
		res.acc = acc;
		res.flg = flg;
		res.two_byte = 1'b0;
		if (op[7:4] == `OP_LOAD_SHORT_HI) begin
			res.acc = {4'h0, op[3:0]};
		end else begin
			case (op)
				`ADD_CARRY_OP: begin
					cin = flg.cry;
					do_add = 1'b1;
				end
				`OP_INCREMENT: begin
					opb = 8'h01;
					do_add = 1'b1;
				end
				`OP_ADD_IMM: begin
					opb = imm;
					do_add = 1'b1;
					res.two_byte = 1'b1;
				end
				`OP_CMP_IMM: begin
					opa = imm;
					opb = ~acc;
					cin = 1'b1;
					do_add = 1'b1;
					keep_acc = 1'b1;
					res.two_byte = 1'b1;
				end
				`OP_AND_IMM: begin
					lres = acc & imm;
					do_log = 1'b1;
					res.two_byte = 1'b1;
				end
				`OP_OR_IMM: begin
					lres = acc | imm;
					do_log = 1'b1;
					res.two_byte = 1'b1;
				end
				`OP_XOR_IMM: begin
					lres = acc ^ imm;
					do_log = 1'b1;
					res.two_byte = 1'b1;
				end
				`OP_COMPLEMENT: begin
					lres = ~acc;
					do_log = 1'b1;
				end
				`OP_LOAD_IMM: begin
					res.acc = imm;
					res.two_byte = 1'b1;
				end
				`OP_SHR1: begin
					lres = {1'b0, acc[7:1]};
					do_log = 1'b1;
				end
				`OP_SHL1: begin
					lres = {acc[6:0], 1'b0};
					do_log = 1'b1;
				end
				`OP_SHR4: begin
					lres = {4'h0, acc[7:4]};
					do_log = 1'b1;
				end
				`OP_SHL4: begin
					lres = {acc[3:0], 4'h0};
					do_log = 1'b1;
				end
				default: begin
					lres = acc;
				end
			endcase
		end
		sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
		c7 = opa[7] ^ opb[7] ^ sum[7];
		// Sign flag is set for a non-negative result.
		if (do_add) begin
			res.flg = '{ovf: sum[8] ^ c7, zero: sum[7:0] == 8'h00, cry: sum[8], sign: ~sum[7]};
			if (!keep_acc) begin
				res.acc = sum[7:0];
			end
		end else if (do_log) begin
			res.flg = '{ovf: 1'b0, zero: lres == 8'h00, cry: 1'b0, sign: ~lres[7]};
			res.acc = lres;
		end
	end

endmodule // acc_alu

// ===== hw/reset_powersave_core_control.sv
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "core_cfg.svh"

// Operation
// - Start reset only when supply, clocks, bias good.
// - Hold reset for the power-on delay.
// - External reset pushes PC, clears PC and flag.
// - Any reset clears ports four to seven.
// - After reset release, fetch from address zero.
// - Test high: bus on port 4, port 5 inputs.
// - Test mid: ROM silent, code from port 5.
// - Test modes: strobe becomes inverted cycle clock; the code drives strobe from mcyc[1] without inversion.
// - Phase clock is system clock halved.
// - Partial sleep halts all but timer, interrupts.
// - Partial sleep wakes on reset or interrupts.
// - Full sleep halts all; reset or external wakes.
// - Full sleep resets timer unless event counting.
// - Interrupt wake: service if enabled, else continue.
// - Reset wake restarts through reset sequence.
// - Increment adds one in one cycle.
// - OR immediate, two and a half cycles.
// - Vectors 020 timer, 0A0 external; clear latch.
// - Event mode: control bits 4 to 7 clear.
module reset_powersave_core_control
	import core_pkg::*;
#(
	parameter int POR_CYCLES = `POR_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Asynchronous pins and sensors
	input wire logic rst_pin_n,
	input wire logic external_irq_pin,
	input wire logic [1:0] test_level,
	input wire logic [7:0] port5_in,
	input wire logic supply_ok,
	input wire logic clocks_ok,
	input wire logic bias_ok,
	// On-chip sources
	input wire logic [7:0] rom_data,
	input wire logic timer_timeout,
	input wire logic strobe_req,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Program memory, ports and status
	output logic [11:0] rom_addr,
	output logic rom_en,
	output port_bank_type ports_out,
	output logic strobe_out,
	output logic timer_reset,
	output logic timer_halt,
	output logic core_halted
);

	localparam core_state_type CORE_RESET = '{state: ST_POR_WAIT, default: '0};

	core_state_type st_ff, nxt_st;
	pin_bundle_type pin_raw, pin;
	test_mode_type tmode;
	alu_res_type alu;
	logic [7:0] bus;
	logic [7:0] alu_op;
	logic [3:0] phi_total;
	logic [1:0] pidx;
	logic ev_mode, act_lvl, tick, wake, vec_go, enter_rst;

	if (POR_CYCLES < 1 || POR_CYCLES > 65535) begin : g_bad_por
		$error("POR_CYCLES must lie in 1..65535");
	end

	// ======================================================================
	// Pin synchronisers and decoder.
	assign pin_raw = '{rst_n: rst_pin_n, ext_irq: external_irq_pin, test: test_level,
		port5: port5_in, supply_ok: supply_ok, clocks_ok: clocks_ok, bias_ok: bias_ok};

	pin_sync #(.W($bits(pin_bundle_type))) u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pin_in(pin_raw),
		.pin_out(pin)
	);

	acc_alu u_alu (
		.op(alu_op),
		.imm(st_ff.imm),
		.acc(st_ff.acc),
		.flg(st_ff.flg),
		.res(alu)
	);

	// Test level, internal data bus and mode decode.
	assign tmode = (pin.test == `TEST_OFF) ? TM_OFF : ((pin.test == `TEST_MID) ? TM_MID : TM_HIGH);
	assign rom_en = (tmode != TM_MID);
	// In test modes port 5 is wired-OR onto the bus and is driven active low.
	assign bus = (rom_en ? rom_data : 8'h00) | ((tmode != TM_OFF) ? ~pin.port5 : 8'h00);
	assign ev_mode = !st_ff.timer_irq_control_reg[`CTRL_MODE]
		&& (st_ff.timer_irq_control_reg[`CTRL_PRESC] == 3'h0);
	assign act_lvl = st_ff.timer_irq_control_reg[`CTRL_EXT_HI] ? pin.ext_irq : ~pin.ext_irq;
	assign alu_op = (st_ff.state == ST_FETCH) ? bus : st_ff.op;
	assign phi_total = alu.two_byte ? `PHI_LONG_CYC : `PHI_ONE_CYC;
	assign pidx = 2'(reg_addr - `REG_PORT4);
	assign tick = st_ff.phi;

	// ======================================================================
	// Next-state logic.
	always_comb begin
		nxt_st = st_ff;
		enter_rst = 1'b0;
		vec_go = 1'b0;
		wake = 1'b0;
		nxt_st.phi = ~st_ff.phi;
		nxt_st.timer_rst = 1'b0;
		nxt_st.rdata = 16'h0000;
		if (tick) begin
			nxt_st.mcyc = st_ff.mcyc + 2'h1;
		end
		nxt_st.strobe = (tmode != TM_OFF) ? st_ff.mcyc[1] : strobe_req;
		nxt_st.p4 = (tmode != TM_OFF) ? bus : st_ff.ports[0];
		nxt_st.ext_prev = act_lvl;
		if (!st_ff.timer_irq_control_reg[`CTRL_EXT_EN]) begin
			nxt_st.ext_req = 1'b0;
		end

		// Register writes.
		if (reg_wr) begin
			if (reg_addr == `REG_TIMER_IRQ_CONTROL) begin
				nxt_st.timer_irq_control_reg = reg_wdata[7:0];
			end else if (reg_addr == `REG_STATUS) begin
				nxt_st.irq_control_flag = reg_wdata[`ST_IRQ_FLAG];
			end else if (reg_addr >= `REG_PORT4 && reg_addr <= `REG_PORT7) begin
				nxt_st.ports[pidx] = reg_wdata[7:0];
			end
		end

		// Register reads; unmapped addresses read zero.
		if (reg_rd) begin
			if (reg_addr == `REG_TIMER_IRQ_CONTROL) begin
				nxt_st.rdata = {8'h00, st_ff.timer_irq_control_reg};
			end else if (reg_addr == `REG_STATUS) begin
				nxt_st.rdata = {6'h00, st_ff.tmr_req, st_ff.ext_req, 3'(st_ff.state),
					st_ff.irq_control_flag, st_ff.flg};
			end else if (reg_addr == `REG_ACC) begin
				nxt_st.rdata = {8'h00, st_ff.acc};
			end else if (reg_addr == `REG_PC) begin
				nxt_st.rdata = {4'h0, st_ff.pc};
			end else if (reg_addr == `REG_STACK) begin
				nxt_st.rdata = {4'h0, st_ff.stack};
			end else if (reg_addr >= `REG_PORT4 && reg_addr <= `REG_PORT7) begin
				nxt_st.rdata = {8'h00, st_ff.ports[pidx]};
			end
		end

		// Sequencer.
		case (st_ff.state)
			ST_POR_WAIT: begin
				if (pin.supply_ok && pin.clocks_ok && pin.bias_ok) begin
					nxt_st.state = ST_POR_DELAY;
					nxt_st.cnt = 16'h0000;
				end
			end
			ST_POR_DELAY: begin
				nxt_st.cnt = st_ff.cnt + 16'h0001;
				if (st_ff.cnt == 16'(POR_CYCLES - 1)) begin
					enter_rst = 1'b1;
				end
			end
			ST_EXT_RST: begin
				if (pin.rst_n) begin
					nxt_st.state = ST_FETCH;
					nxt_st.cnt = 16'h0000;
				end
			end
			ST_FETCH: begin
				if (tick) begin
					nxt_st.op = bus;
					nxt_st.pc = st_ff.pc + 12'h001;
					nxt_st.cnt = 16'h0001;
					if (bus == `PARTIAL_SLEEP_OP) begin
						nxt_st.state = ST_PART_SLEEP;
					end else if (bus == `FULL_SLEEP_OP) begin
						nxt_st.state = ST_FULL_SLEEP;
						nxt_st.timer_rst = !ev_mode;
					end else begin
						nxt_st.state = alu.two_byte ? ST_OPERAND : ST_EXEC;
					end
				end
			end
			ST_OPERAND: begin
				if (tick) begin
					nxt_st.imm = bus;
					nxt_st.pc = st_ff.pc + 12'h001;
					nxt_st.cnt = st_ff.cnt + 16'h0001;
					nxt_st.state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (tick) begin
					nxt_st.cnt = st_ff.cnt + 16'h0001;
					if ((st_ff.cnt[3:0] + 4'h1) == phi_total) begin
						nxt_st.acc = alu.acc;
						nxt_st.flg = alu.flg;
						nxt_st.state = ST_FETCH;
						vec_go = st_ff.irq_control_flag && (st_ff.tmr_req || st_ff.ext_req);
					end
				end
			end
			ST_PART_SLEEP: begin
				wake = st_ff.tmr_req || st_ff.ext_req;
			end
			ST_FULL_SLEEP: begin
				wake = st_ff.ext_req;
			end
			default: begin
				nxt_st.state = ST_POR_WAIT;
			end
		endcase

		// Interrupt wake services the request or resumes at the next opcode.
		if (wake) begin
			nxt_st.state = ST_FETCH;
			vec_go = st_ff.irq_control_flag;
		end

		// Vectoring; the timer request has priority.
		if (vec_go) begin
			nxt_st.stack = nxt_st.pc;
			nxt_st.state = ST_FETCH;
			if (st_ff.tmr_req) begin
				nxt_st.pc = `VEC_TIMER;
				nxt_st.tmr_req = 1'b0;
			end else begin
				nxt_st.pc = `VEC_EXT;
				nxt_st.ext_req = 1'b0;
			end
		end

		// External reset from any running or sleeping state.
		if (!pin.rst_n && st_ff.state != ST_POR_WAIT && st_ff.state != ST_POR_DELAY
			&& st_ff.state != ST_EXT_RST) begin
			enter_rst = 1'b1;
		end
		if (enter_rst) begin
			nxt_st.stack = st_ff.pc;
			nxt_st.pc = `RESET_PC;
			nxt_st.irq_control_flag = 1'b0;
			nxt_st.ports = {4{`PORT_CLEAR}};
			nxt_st.state = ST_EXT_RST;
		end

		// Request latches: a new event wins over a clear in the same cycle.
		if (timer_timeout) begin
			nxt_st.tmr_req = 1'b1;
		end
		if (st_ff.timer_irq_control_reg[`CTRL_EXT_EN] && act_lvl && !st_ff.ext_prev) begin
			nxt_st.ext_req = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= CORE_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs.
	assign reg_rdata = st_ff.rdata;
	assign rom_addr = st_ff.pc;
	assign ports_out = {st_ff.ports[3], st_ff.ports[2], st_ff.ports[1], st_ff.p4};
	assign strobe_out = st_ff.strobe;
	assign timer_reset = st_ff.timer_rst;
	assign timer_halt = (st_ff.state == ST_FULL_SLEEP);
	assign core_halted = (st_ff.state == ST_PART_SLEEP) || (st_ff.state == ST_FULL_SLEEP);

	// ======================================================================
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence rst_release_s;
		st_ff.state == ST_EXT_RST && pin.rst_n;
	endsequence

	sequence fsave_fetch_s;
		st_ff.state == ST_FETCH && tick && bus == `FULL_SLEEP_OP && pin.rst_n;
	endsequence

	por_gate_a: assert property (
		st_ff.state == ST_POR_WAIT && !(pin.supply_ok && pin.clocks_ok && pin.bias_ok)
		|=> st_ff.state == ST_POR_WAIT) else $error("Reset started before sensors were good.");

	por_delay_a: assert property (
		st_ff.state == ST_POR_DELAY && st_ff.cnt < 16'(POR_CYCLES - 1)
		|=> st_ff.state == ST_POR_DELAY && st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
		else $error("Power-on delay ended early.");

	ext_reset_a: assert property (
		enter_rst |=> st_ff.pc == `RESET_PC && !st_ff.irq_control_flag
		&& st_ff.stack == $past(st_ff.pc)) else $error("Reset did not push and clear.");

	port_clear_a: assert property (
		enter_rst |=> st_ff.ports == {4{`PORT_CLEAR}} && st_ff.state == ST_EXT_RST)
		else $error("Reset did not clear ports.");

	first_fetch_a: assert property (
		rst_release_s |=> st_ff.state == ST_FETCH && rom_addr == `RESET_PC)
		else $error("First fetch not at zero.");

	test_bus_a: assert property (
		tmode != TM_OFF |=> ports_out[0] == $past(bus)) else $error("Bus not on port 4.");

	mid_rom_a: assert property (
		tmode == TM_MID |-> !rom_en && bus == ~pin.port5) else $error("ROM drives bus in mid test.");

	strobe_clk_a: assert property (
		tmode != TM_OFF |=> strobe_out == $past(st_ff.mcyc[1])) else $error("Strobe not cycle clock.");

	phase_div_a: assert property (
		st_ff.phi |=> !st_ff.phi ##1 st_ff.phi) else $error("Phase clock not halved.");

	full_hold_a: assert property (
		st_ff.state == ST_FULL_SLEEP && !st_ff.ext_req && pin.rst_n |=> st_ff.state == ST_FULL_SLEEP)
		else $error("Full sleep left without cause.");

	sleep_timer_a: assert property (
		fsave_fetch_s |=> timer_reset == !$past(ev_mode) ##1 !timer_reset)
		else $error("Timer reset wrong on full sleep.");

	vector_a: assert property (
		vec_go && st_ff.tmr_req && pin.rst_n |=> rom_addr == `VEC_TIMER)
		else $error("Timer vector wrong.");

endmodule // reset_powersave_core_control

// ===== testbench/pin_rom_model.sv
`timescale 1ns/1ns
`include "core_cfg.svh"

// ==========================================================================
// Program memory with the reset and test pin drivers that sit outside the core.
module pin_rom_model (
	// Clock
	input wire logic clk_sys,
	// Program memory read and load
	input wire logic [11:0] rom_addr,
	output logic [7:0] rom_data,
	input wire logic load_en,
	input wire logic [11:0] load_addr,
	input wire logic [7:0] load_data,
	// Pin requests from the bench
	input wire logic hold_reset,
	input wire logic [1:0] test_req,
	output logic rst_pin_n,
	output logic [1:0] test_level
);
	logic [7:0] mem_ff [0:4095];

	// Unused locations hold the partial sleep opcode so a stray fetch parks the core.
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem_ff[i] = `PARTIAL_SLEEP_OP;
		end
	end

	// Loads arrive on the clock like any synchronous write.
	always @(posedge clk_sys) begin
		if (load_en) begin
			mem_ff[load_addr] <= load_data;
		end
	end

	// The memory answers at once; the pins follow the requests, test idling at ground.
	assign rom_data = mem_ff[rom_addr];
	assign rst_pin_n = ~hold_reset;
	assign test_level = test_req;
endmodule // pin_rom_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`include "core_cfg.svh"

`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); \
	end \
end

module tb_top
	import core_pkg::*;
;
	localparam int POR = 20;
	logic clk_sys = 1'b0, nrst = 1'b0, external_irq_pin = 1'b1, timer_timeout = 1'b0;
	logic supply_ok = 1'b0, clocks_ok = 1'b0, bias_ok = 1'b0, strobe_req = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, load_en = 1'b0, hold_reset = 1'b0;
	logic [7:0] port5_in = 8'hFF, load_data = 8'h00, rom_data, r, ii, expv, a1;
	logic [1:0] test_req = 2'h0, test_level;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
	logic [11:0] rom_addr, load_addr = 12'h000;
	logic rst_pin_n, rom_en, strobe_out, timer_reset, timer_halt, core_halted, strobe_prev;
	logic [7:0] prog [6];
	port_bank_type ports_out;
	int miscompares = 0, comparisons = 0, cycles = 0, treset_cnt = 0, strobe_cnt = 0;
	int seed, c0;

	reset_powersave_core_control #(.POR_CYCLES(POR)) dut (.clk_sys(clk_sys), .nrst(nrst),
		.rst_pin_n(rst_pin_n), .external_irq_pin(external_irq_pin), .test_level(test_level),
		.port5_in(port5_in), .supply_ok(supply_ok), .clocks_ok(clocks_ok), .bias_ok(bias_ok),
		.rom_data(rom_data), .timer_timeout(timer_timeout), .strobe_req(strobe_req),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rom_addr(rom_addr), .rom_en(rom_en), .ports_out(ports_out),
		.strobe_out(strobe_out), .timer_reset(timer_reset), .timer_halt(timer_halt),
		.core_halted(core_halted));

	pin_rom_model far (.clk_sys(clk_sys), .rom_addr(rom_addr), .rom_data(rom_data),
		.load_en(load_en), .load_addr(load_addr), .load_data(load_data),
		.hold_reset(hold_reset), .test_req(test_req), .rst_pin_n(rst_pin_n),
		.test_level(test_level));

	// ======================================================================
	// Clock, monitors and the hang guard.
	always #20 clk_sys = ~clk_sys;

	// Counts timer reset pulses and strobe rises, and cuts a hang short.
	always @(posedge clk_sys) begin
		cycles++;
		if (timer_reset === 1'b1) treset_cnt++;
		if (strobe_out === 1'b1 && strobe_prev !== 1'b1) strobe_cnt++;
		strobe_prev = strobe_out;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	// ======================================================================
	// Bus tasks and expectations.
	task automatic final_report();
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// The read data stand only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask

	task automatic load(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		load_en <= 1'b1;
		load_addr <= a;
		load_data <= d;
		@(posedge clk_sys);
		load_en <= 1'b0;
	endtask

	task automatic pulse_timer();
		@(posedge clk_sys);
		timer_timeout <= 1'b1;
		@(posedge clk_sys);
		timer_timeout <= 1'b0;
	endtask

	// Polls the status state field under a bounded count.
	task automatic wait_state(input logic [2:0] s);
		rd(`REG_STATUS, v);
		for (int i = 0; i < 100 && v[7:5] !== s; i++) rd(`REG_STATUS, v);
	endtask

	// Flags after a logic operation: overflow and carry clear, sign set when non-negative.
	function automatic logic [3:0] or_flags(input logic [7:0] a);
		return {1'b0, a == 8'h00, 1'b0, ~a[7]};
	endfunction

	// ======================================================================
	// Main sequence.
	initial begin
		seed = 92081;
		r = 8'($random(seed));
		ii = 8'($random(seed));
		expv = (r + 8'h01) | ii;
		prog = '{`OP_LOAD_IMM, r, `OP_INCREMENT, `OP_OR_IMM, ii, `FULL_SLEEP_OP};
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) load(12'(i), prog[i]);
		load(12'h021, `FULL_SLEEP_OP);
		wr(`REG_TIMER_IRQ_CONTROL, 16'h0021);
		for (int i = 0; i < 4; i++) wr(4'(`REG_PORT4 + i), {8'h00, 8'($random(seed))});
		// Any single missing sensor keeps the power-on clear waiting.
		for (int i = 0; i < 3; i++) begin
			{supply_ok, clocks_ok, bias_ok} <= 3'b111 ^ (3'b001 << i);
			repeat (30) @(posedge clk_sys);
			rd(`REG_STATUS, v);
			`CHK(v[7:5], 3'h0)
		end
		{supply_ok, clocks_ok, bias_ok} <= 3'b111;
		repeat (14) @(posedge clk_sys);
		rd(`REG_STATUS, v);
		`CHK(v[7:5], 3'h1)
		repeat (10) @(posedge clk_sys);
		rd(`REG_STATUS, v);
		`CHK(v[7:6] != 2'b00, 1'b1)
		wait_state(3'h7);
		`CHK({v[7:5], v[3:0]}, {3'h7, or_flags(expv)})
		rd(`REG_ACC, v);
		`CHK(v[7:0], expv)
		for (int i = 0; i < 4; i++) `CHK(ports_out[i], 8'h00)
		`CHK({treset_cnt == 1, timer_halt, core_halted}, 3'b111)
		// Serviced wake by the external pin, then by the timer.
		wr(`REG_STATUS, 16'h0010);
		external_irq_pin <= 1'b0;
		wait_state(3'h6);
		`CHK({v[8], v[7:5]}, 4'h6)
		rd(`REG_STACK, v);
		`CHK(v[11:0], 12'h006)
		pulse_timer();
		repeat (40) @(posedge clk_sys);
		rd(`REG_STATUS, v);
		`CHK({v[9], v[7:5], core_halted, timer_halt}, 6'b011010)
		rd(`REG_STACK, v);
		`CHK(v[11:0], 12'h0A1)
		rd(`REG_PC, v);
		`CHK(v[11:0], 12'h021)
		// Wake with service disabled continues into a full sleep.
		wr(`REG_STATUS, 16'h0000);
		pulse_timer();
		wait_state(3'h7);
		`CHK({v[9], v[7:5]}, 4'hF)
		`CHK(treset_cnt, 2)
		pulse_timer();
		repeat (20) @(posedge clk_sys);
		rd(`REG_STATUS, v);
		`CHK(v[7:5], 3'h7)
		// Non-zero port contents so that the reset clear is visible.
		for (int i = 0; i < 4; i++) wr(4'(`REG_PORT4 + i), {8'h00, 8'($random(seed)) | 8'h01});
		repeat (2) @(posedge clk_sys);
		`CHK(ports_out[1] != 8'h00, 1'b1)
		// External reset from full sleep.
		hold_reset <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rd(`REG_STATUS, v);
		`CHK(v[7:4], 4'h4)
		rd(`REG_STACK, v);
		`CHK(v[11:0], 12'h022)
		`CHK(rom_addr, `RESET_PC)
		for (int i = 0; i < 4; i++) `CHK(ports_out[i], 8'h00)
		rd(`REG_TIMER_IRQ_CONTROL, v);
		`CHK(v[7:0], 8'h21)
		rd(`REG_ACC, v);
		`CHK(v[7:0], expv)
		// Mid test level: code arrives inverted on port 5 and the bus shows on port 4.
		test_req <= `TEST_MID;
		port5_in <= ~`OP_INCREMENT;
		hold_reset <= 1'b0;
		repeat (40) @(posedge clk_sys);
		`CHK({rom_en, ports_out[0]}, {1'b0, `OP_INCREMENT})
		rd(`REG_ACC, v);
		a1 = v[7:0];
		c0 = strobe_cnt;
		repeat (78) @(posedge clk_sys);
		rd(`REG_ACC, v);
		`CHK(v[7:0] - a1, 8'h0A)
		`CHK(strobe_cnt - c0, 10)
		test_req <= 2'h2;
		port5_in <= 8'hFF;
		repeat (8) @(posedge clk_sys);
		`CHK(rom_en, 1'b1)
		test_req <= `TEST_OFF;
		strobe_req <= 1'b1;
		repeat (8) @(posedge clk_sys);
		`CHK(strobe_out, 1'b1)
		final_report();
	end
endmodule // tb_top
